/* File: ssw_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssw_map.svh"

module ssw_top
    import ssw_pkg::*;
#(
    parameter int MS_CYCLES = `SSW_CLK_KHZ * `SSW_TICK_MS,
    parameter int WAKE_CYCLES = `SSW_WAKE_US * `SSW_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic spi_clk_i,
    input wire logic spi_cs_b_i,
    input wire logic spi_di_i,
    input wire logic main_rail_ok_i,
    input wire logic second_rail_ok_i,
    input wire logic third_rail_ok_i,
    input wire logic main_rail_retain_i,
    input wire logic main_rail_brownout_i,
    input wire logic second_rail_brownout_i,
    input wire logic temp_warn_i,
    input wire logic temp_shutdown_i,
    input wire logic wake_i,
    input wire logic [5:0] sensor_settled_i,
    input wire logic dcdc_running_i,
    output logic spi_do_o,
    output logic spi_do_oe_o,
    output logic main_rail_reset_n_o,
    output logic second_rail_reset_n_o,
    output logic third_rail_reset_n_o,
    output logic fault_n_o,
    output logic [5:0] sensor_supply_outputs_o,
    output logic regulators_enable_o
);

    localparam int IN_W = 19;
    localparam int MSW = $clog2(MS_CYCLES);
    localparam int WKW = $clog2(WAKE_CYCLES + 1);

    function automatic logic [7:0] sel_ms(input logic lo, input logic hi, input logic [7:0] base);
        sel_ms = base << {~hi, ~lo};
    endfunction

    logic [IN_W-1:0] raw;
    logic [IN_W-1:0] syn;
    logic sck;
    logic cs_b;
    logic di;
    logic [2:0] rail_ok;
    logic retain;
    logic brown_a;
    logic brown_b;
    logic twarn;
    logic tsd;
    logic wake;
    logic [5:0] trk_ok;
    logic dcdc;

    assign raw = {dcdc_running_i, sensor_settled_i, wake_i, temp_shutdown_i, temp_warn_i,
                  second_rail_brownout_i, main_rail_brownout_i, main_rail_retain_i,
                  third_rail_ok_i, second_rail_ok_i, main_rail_ok_i,
                  spi_di_i, spi_cs_b_i, spi_clk_i};

    ssw_sync #(
        .W(IN_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(raw),
        .q_o(syn)
    );

    assign sck = syn[0];
    assign cs_b = syn[1];
    assign di = syn[2];
    assign rail_ok = syn[5:3];
    assign retain = syn[6];
    assign brown_a = syn[7];
    assign brown_b = syn[8];
    assign twarn = syn[9];
    assign tsd = syn[10];
    assign wake = syn[11];
    assign trk_ok = syn[17:12];
    assign dcdc = syn[18];

    logic sck_q;
    logic cs_q;
    logic sck_rise;
    logic cs_fall;
    logic cs_rise;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [15:0] sr;
    logic [4:0] bit_cnt;
    logic [15:0] ctrl;
    logic [15:0] status;
    logic xfer_done;
    logic accept;
    logic kick;
    logic wd_en;
    logic [7:0] rdly;
    logic [7:0] wlen;
    logic [7:0] dly_cnt [3];
    logic [MSW-1:0] dly_sub [3];
    logic [MSW-1:0] wd_sub;
    logic wd_tick;
    ssw_wd_state_t wd_last;
    logic err_live;
    logic [2:0] rst_n;
    logic [1:0] ret;
    logic [1:0] trk_age [6];
    logic [5:0] trk_fault;
    logic err_src;
    logic err_latch;
    logic wd_err;
    logic wd_fail;
    logic wd_force;
    ssw_wd_state_t wd_state;
    logic [7:0] wd_cnt;
    logic [7:0] win;
    logic [WKW-1:0] wake_cnt;
    logic powered;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    assign sck_rise = sck & ~sck_q;
    assign cs_fall = ~cs_b & cs_q;
    assign cs_rise = cs_b & ~cs_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sck_q <= 1'b0;
            cs_q <= 1'b0;
        end
        else
        begin
            sck_q <= sck;
            cs_q <= cs_b;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end
        else
        begin
            ms_tick <= (ms_cnt == MSW'(MS_CYCLES - 1));
            ms_cnt <= (ms_cnt == MSW'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
        end
    end

    // one shifter both receives and transmits, so after 16 clocks the data out
    // repeats what came in, which is what a daisy chain needs
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sr <= '0;
            bit_cnt <= '0;
            spi_do_o <= 1'b0;
            spi_do_oe_o <= 1'b0;
        end
        else if (cs_fall)
        begin
            sr <= status;
            spi_do_o <= status[0];
            spi_do_oe_o <= 1'b1;
            bit_cnt <= '0;
        end
        else if (cs_rise)
        begin
            spi_do_oe_o <= 1'b0;
        end
        else if (~cs_b && sck_rise)
        begin
            sr <= {di, sr[15:1]};
            spi_do_o <= sr[1];
            if (bit_cnt != 5'h10)
            begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // a short frame is dropped whole; two 8-bit bursts inside one select count as one word
    assign xfer_done = cs_rise & (bit_cnt == 5'h10);
    assign accept = xfer_done & rst_n[0];
    assign kick = accept & sr[`SSW_KICK_POS];

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl <= `SSW_CTRL_RESET;
        end
        else if (~retain)
        begin
            ctrl <= `SSW_CTRL_RESET;
        end
        else if (accept)
        begin
            ctrl <= sr;
        end
    end

    assign wd_en = ~ctrl[`SSW_WD_OFF_A_POS] & ctrl[`SSW_WD_OFF_B_POS] & ~ctrl[`SSW_WD_OFF_C_POS];
    assign rdly = sel_ms(ctrl[`SSW_RDLY_LO_POS], ctrl[`SSW_RDLY_HI_POS], `SSW_RDLY_BASE_MS);
    assign wlen = sel_ms(ctrl[`SSW_WIN_LO_POS], ctrl[`SSW_WIN_HI_POS], `SSW_WIN_BASE_MS);

    assign status = {dcdc, wd_err, ~rst_n[2], ~rst_n[1], ~rst_n[0], (wd_state == wd_closed),
                     ret, trk_ok & ctrl[`SSW_SENSOR_HI_POS:`SSW_SENSOR_LO_POS], twarn, err_latch};

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 3; i++)
            begin
                dly_cnt[i] <= '0;
                dly_sub[i] <= '0;
            end
            rst_n <= '0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (~rail_ok[i] || (i == 0 && wd_force))
                begin
                    dly_cnt[i] <= '0;
                    dly_sub[i] <= '0;
                    rst_n[i] <= 1'b0;
                end
                else if (dly_cnt[i] >= rdly)
                begin
                    rst_n[i] <= 1'b1;
                end
                // own prescaler per rail, so the tick phase never cuts the delay short
                else if (dly_sub[i] == MSW'(MS_CYCLES - 1))
                begin
                    dly_sub[i] <= '0;
                    dly_cnt[i] <= dly_cnt[i] + 8'h01;
                end
                else
                begin
                    dly_sub[i] <= dly_sub[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            main_rail_reset_n_o <= 1'b0;
            second_rail_reset_n_o <= 1'b0;
            third_rail_reset_n_o <= 1'b0;
        end
        else
        begin
            main_rail_reset_n_o <= rst_n[0];
            second_rail_reset_n_o <= rst_n[1];
            third_rail_reset_n_o <= rst_n[2];
        end
    end

    // set beats clear for every sticky flag
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ret <= '0;
        end
        else
        begin
            ret <= (xfer_done ? 2'h0 : ret) | {brown_b, brown_a};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 6; i++)
            begin
                trk_age[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (~sensor_supply_outputs_o[i])
                begin
                    trk_age[i] <= '0;
                end
                else if (ms_tick && trk_age[i] != `SSW_SETTLE_TICKS)
                begin
                    trk_age[i] <= trk_age[i] + 2'h1;
                end
            end
        end
    end

    // two ticks guarantee at least one full millisecond after enable
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            trk_fault[i] = (trk_age[i] == `SSW_SETTLE_TICKS) & ~trk_ok[i];
        end
    end

    assign err_src = twarn | wd_err | (|ret) | (|trk_fault);
    // at a completed frame only live causes may set the latch again, not flags cleared with it
    assign err_live = twarn | brown_a | brown_b | (|trk_fault) | wd_fail;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            err_latch <= 1'b0;
            wd_err <= 1'b0;
            fault_n_o <= 1'b1;
        end
        else
        begin
            err_latch <= xfer_done ? err_live : (err_latch | err_src);
            wd_err <= (wd_err & ~xfer_done) | wd_fail;
            fault_n_o <= ~(err_src | err_latch | wd_fail);
        end
    end

    assign wd_fail = wd_en & (((wd_state == wd_closed) & kick) |
                     ((wd_state == wd_open) & ~kick & (wd_cnt >= win)));
    assign wd_force = wd_en & (wd_state == wd_fault) & (wd_cnt >= {1'b0, win[7:1]});
    assign wd_tick = (wd_sub == MSW'(MS_CYCLES - 1)) & (wd_state == wd_last);

    // the window prescaler restarts with every state change, so windows are whole ms
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wd_sub <= '0;
            wd_last <= wd_idle;
        end
        else
        begin
            wd_last <= wd_state;
            wd_sub <= ((wd_state != wd_last) || wd_tick) ? '0 : wd_sub + 1'b1;
        end
    end

    // disabling clears wd_cnt and the state at once, and the prescaler restarts at re-enable, so any gap before re-enable is enough
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wd_state <= wd_idle;
            wd_cnt <= '0;
            win <= `SSW_WIN_BASE_MS;
        end
        else if (~wd_en)
        begin
            wd_state <= wd_idle;
            wd_cnt <= '0;
        end
        else
        begin
            unique case (wd_state)
                wd_idle:
                begin
                    wd_state <= wd_wait;
                end
                wd_wait:
                begin
                    if (rst_n[0])
                    begin
                        wd_state <= wd_closed;
                        win <= wlen;
                        wd_cnt <= '0;
                    end
                end
                wd_closed:
                begin
                    if (wd_fail || ~rst_n[0])
                    begin
                        wd_state <= wd_fail ? wd_fault : wd_wait;
                        wd_cnt <= '0;
                    end
                    else if (wd_cnt >= win)
                    begin
                        wd_state <= wd_open;
                        wd_cnt <= '0;
                    end
                    else if (wd_tick)
                    begin
                        wd_cnt <= wd_cnt + 8'h01;
                    end
                end
                wd_open:
                begin
                    if (wd_fail || ~rst_n[0])
                    begin
                        wd_state <= wd_fail ? wd_fault : wd_wait;
                        wd_cnt <= '0;
                    end
                    else if (kick)
                    begin
                        wd_state <= wd_closed;
                        win <= wlen;
                        wd_cnt <= '0;
                    end
                    else if (wd_tick)
                    begin
                        wd_cnt <= wd_cnt + 8'h01;
                    end
                end
                wd_fault:
                begin
                    if (wd_force)
                    begin
                        wd_state <= wd_wait;
                        wd_cnt <= '0;
                    end
                    else if (wd_tick)
                    begin
                        wd_cnt <= wd_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wake_cnt <= '0;
            powered <= 1'b0;
        end
        else
        begin
            wake_cnt <= wake ? ((wake_cnt == WKW'(WAKE_CYCLES)) ? wake_cnt : wake_cnt + 1'b1) : '0;
            if (wake && wake_cnt == WKW'(WAKE_CYCLES - 1))
            begin
                powered <= 1'b1;
            end
            else if (accept && ~sr[`SSW_SLEEP_POS] && ~wake)
            begin
                powered <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            regulators_enable_o <= 1'b0;
            sensor_supply_outputs_o <= '0;
        end
        else
        begin
            regulators_enable_o <= powered & ~tsd;
            sensor_supply_outputs_o <= ctrl[`SSW_SENSOR_HI_POS:`SSW_SENSOR_LO_POS] & {6{powered & ~tsd}};
        end
    end

    early_kick_a: assert property ((wd_state == wd_closed) && kick && wd_en |=> wd_err ##1 !fault_n_o)
        else $error("early kick not flagged");
    late_reset_a: assert property ($rose(wd_state == wd_fault) |-> !wd_force [*3])
        else $error("watchdog reset without half window wait");
    fault_pin_a: assert property (wd_err |=> !fault_n_o)
        else $error("fault pin high with watchdog error");
    cold_ctrl_a: assert property (!retain |=> ctrl == `SSW_CTRL_RESET)
        else $error("control word kept after cold start");
    ignore_cmd_a: assert property (cs_rise && !rst_n[0] && retain |=> $stable(ctrl))
        else $error("command taken during reset");
    ret_clear_a: assert property (xfer_done && !brown_a && !brown_b |=> ret == 2'h0)
        else $error("retention flags not cleared");
    wd_stop_a: assert property (!wd_en |=> wd_state == wd_idle && wd_cnt == 8'h00)
        else $error("watchdog running while disabled");
    rail_hold_a: assert property (!rail_ok[0] |=> ##1 !main_rail_reset_n_o)
        else $error("main reset released without rail");
    do_release_a: assert property (cs_rise |=> !spi_do_oe_o)
        else $error("data out still driven after select");
    sleep_cmd_a: assert property (accept && !sr[`SSW_SLEEP_POS] && !wake |=> ##1 !regulators_enable_o)
        else $error("sleep request ignored");
    first_cw_a: assert property ((wd_state == wd_wait) && !rst_n[0] |=> wd_state != wd_closed)
        else $error("closed window during reset delay");

endmodule // ssw_top

`default_nettype wire

/* File: ssw_map.svh */
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH

`define SSW_WORD_BITS 16
`define SSW_CTRL_RESET 16'h4DFD
`define SSW_WD_OFF_A_POS 0
`define SSW_SENSOR_LO_POS 2
`define SSW_SENSOR_HI_POS 7
`define SSW_SLEEP_POS 8
`define SSW_WD_OFF_B_POS 9
`define SSW_RDLY_LO_POS 10
`define SSW_RDLY_HI_POS 11
`define SSW_WIN_LO_POS 12
`define SSW_WIN_HI_POS 13
`define SSW_WD_OFF_C_POS 14
`define SSW_KICK_POS 15

`define SSW_RDLY_BASE_MS 8'h08
`define SSW_WIN_BASE_MS 8'h10
`define SSW_SETTLE_TICKS 2'h2

`define SSW_CLK_KHZ 250000
`define SSW_CLK_MHZ 250
`define SSW_TICK_MS 1
`define SSW_WAKE_US 50

`endif

/* File: ssw_pkg.sv */
package ssw_pkg;

    typedef enum logic [2:0] {wd_idle, wd_wait, wd_closed, wd_open, wd_fault} ssw_wd_state_t;

endpackage

/* File: ssw_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module ssw_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // a level change is accepted only once the second and third stages agree
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_o <= '0;
        end
        else
        begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= (s2 & s3) | (q_o & (s2 | s3));
        end
    end

endmodule // ssw_sync

`default_nettype wire

/* File: ssw_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none

module ssw_spi_host (
    output logic spi_clk_o,
    output logic spi_cs_b_o,
    output logic spi_di_o,
    input wire logic spi_do_i,
    input wire logic spi_do_oe_i
);
    initial
    begin
        spi_clk_o = 1'b0;
        spi_cs_b_o = 1'b1;
        spi_di_o = 1'b0;
    end

    // shift clock stands low between frames; idle data shows the inverse of the last bit
    // so a design that samples outside a frame cannot read a lucky value
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
        rd = 32'h0;
        spi_cs_b_o <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_di_o <= w[i];
            #62.5;
            spi_clk_o <= 1'b1;
            rd[i] = spi_do_oe_i ? spi_do_i : ~spi_di_o;
            #62.5;
            spi_clk_o <= 1'b0;
        end
        #62.5;
        spi_cs_b_o <= 1'b1;
        spi_di_o <= ~spi_di_o;
    endtask
endmodule // ssw_spi_host

`default_nettype wire

/* File: ssw_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module ssw_top_tb_top;
    import ssw_pkg::*;
    localparam int MS = 50;
    typedef struct {logic [1:0] code; int ms; logic [5:0] pat;} ssw_row_t;
    ssw_row_t rows [4] = '{'{2'b11, 8, 6'h15}, '{2'b10, 16, 6'h2A},
                           '{2'b01, 32, 6'h0F}, '{2'b00, 64, 6'h30}};
    logic clk_i, rst_b_i, spi_clk, spi_cs_b, spi_di, spi_do, spi_do_oe;
    logic main_ok, other_ok, retain, bo_main, bo_second, temp_warn, temp_sd, wake;
    logic main_reset_n, second_reset_n, third_reset_n, fault_n, reg_en;
    logic [5:0] sens;
    logic [5:0] settled = 6'h3F;
    logic dcdc = 1'b1;
    logic [15:0] wd;
    logic [31:0] rd;
    int n_errors, check_count, cycles, cnt;

    ssw_top #(.MS_CYCLES(MS), .WAKE_CYCLES(20)) i_ssw_top (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_clk_i(spi_clk), .spi_cs_b_i(spi_cs_b),
        .spi_di_i(spi_di), .main_rail_ok_i(main_ok), .second_rail_ok_i(other_ok),
        .third_rail_ok_i(other_ok), .main_rail_retain_i(retain),
        .main_rail_brownout_i(bo_main), .second_rail_brownout_i(bo_second),
        .temp_warn_i(temp_warn), .temp_shutdown_i(temp_sd), .wake_i(wake),
        .sensor_settled_i(settled), .dcdc_running_i(dcdc), .spi_do_o(spi_do),
        .spi_do_oe_o(spi_do_oe), .main_rail_reset_n_o(main_reset_n),
        .second_rail_reset_n_o(second_reset_n), .third_rail_reset_n_o(third_reset_n),
        .fault_n_o(fault_n), .sensor_supply_outputs_o(sens), .regulators_enable_o(reg_en));

    ssw_spi_host i_ssw_spi_host (.spi_clk_o(spi_clk), .spi_cs_b_o(spi_cs_b),
        .spi_di_o(spi_di), .spi_do_i(spi_do), .spi_do_oe_i(spi_do_oe));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [15:0] mk(input logic kick, input logic wdon, input logic [1:0] win,
        input logic [1:0] rdly, input logic sleep, input logic [5:0] sup);
        return {kick, ~wdon, win, rdly, wdon, sleep, sup, 1'b0, ~wdon};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // gap of 10 clocks keeps frames well apart from the filtered select edge
    task automatic send(input logic [15:0] w);
        i_ssw_spi_host.xfer({16'h0, w}, 16, rd);
        tick(10);
        check("data out enable", spi_do_oe, 1'b0);
    endtask

    task automatic wait_main(input logic lvl, input int max);
        cnt = 0;
        while (main_reset_n !== lvl && cnt < max)
        begin
            @(posedge clk_i);
            cnt++;
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        {rst_b_i, main_ok, other_ok, bo_main, bo_second, temp_warn, temp_sd, wake} = 8'h00;
        retain = 1'b1;
        tick(6);
        check("oe in reset", spi_do_oe, 1'b0);
        check("reset in reset", main_reset_n, 1'b0);
        check("fault in reset", fault_n, 1'b1);
        rst_b_i <= 1'b1;
        wake <= 1'b1;
        tick(10);
        wake <= 1'b0;
        tick(30);
        check("short wake", reg_en, 1'b0);
        wake <= 1'b1;
        tick(40);
        check("wake held", reg_en, 1'b1);
        check("supply default", sens, 6'h3F);
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h00));
        check("frame in reset", sens, 6'h3F);
        main_ok <= 1'b1;
        other_ok <= 1'b1;
        wait_main(1'b1, 1000);
        check("first release", cnt >= 8 * MS && cnt <= 8 * MS + 10, 1'b1);
        tick(10);
        check("second release", second_reset_n & third_reset_n, 1'b1);
        $display("test power-up done");

        foreach (rows[i])
        begin
            send(mk(0, 0, 2'b00, rows[i].code, 1, rows[i].pat));
            check("dcdc status", rd[15], 1'b1);
            check("supplies", sens, rows[i].pat);
            main_ok <= 1'b0;
            tick(10);
            check("reset on rail loss", main_reset_n, 1'b0);
            main_ok <= 1'b1;
            wait_main(1'b1, 4000);
            check("delay", cnt >= rows[i].ms * MS && cnt <= rows[i].ms * MS + 10, 1'b1);
        end
        $display("test delay table done");

        main_ok <= 1'b0;
        retain <= 1'b0;
        tick(10);
        retain <= 1'b1;
        main_ok <= 1'b1;
        wait_main(1'b1, 4000);
        check("defaults delay", cnt >= 8 * MS && cnt <= 8 * MS + 10, 1'b1);
        check("defaults supplies", sens, 6'h3F);
        bo_main <= 1'b1;
        tick(10);
        bo_main <= 1'b0;
        tick(10);
        check("fault on flag", fault_n, 1'b0);
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h3F));
        check("main flag", rd[8], 1'b1);
        check("error bit", rd[0], 1'b1);
        bo_second <= 1'b1;
        tick(10);
        bo_second <= 1'b0;
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h3F));
        check("flags", rd[9:8], 2'b10);
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h3F));
        check("flags cleared", {rd[9:8], rd[0]}, 3'b000);
        check("fault released", fault_n, 1'b1);
        settled <= 6'h3E;
        tick(3 * MS);
        check("unsettled supply", fault_n, 1'b0);
        settled <= 6'h3F;
        temp_warn <= 1'b1;
        tick(10);
        check("fault on temp", fault_n, 1'b0);
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h3F));
        check("temp status", rd[1:0], 2'b11);
        temp_warn <= 1'b0;
        temp_sd <= 1'b1;
        tick(10);
        check("shutdown", reg_en, 1'b0);
        temp_sd <= 1'b0;
        tick(10);
        $display("test flags done");

        i_ssw_spi_host.xfer({8'h00, mk(0, 0, 2'b00, 2'b11, 1, 6'h21), 8'hA5}, 24, rd);
        tick(10);
        check("daisy word", sens, 6'h21);
        check("daisy echo", rd[23:16], 8'hA5);
        i_ssw_spi_host.xfer({16'h0, mk(0, 0, 2'b00, 2'b11, 1, 6'h00)}, 8, rd);
        tick(10);
        check("short frame", sens, 6'h21);
        $display("test daisy done");

        wd = mk(0, 1, 2'b11, 2'b11, 1, 6'h3F);
        send(wd);
        send(wd);
        check("closed flag", rd[10], 1'b1);
        check("no kick bit", fault_n, 1'b1);
        send(wd | 16'h8000);
        check("kick in open", fault_n, 1'b1);
        send(wd | 16'h8000);
        check("early kick", fault_n, 1'b0);
        wait_main(1'b0, 1000);
        check("half window", cnt >= 8 * MS - 20 && cnt <= 8 * MS + 10, 1'b1);
        wait_main(1'b1, 1000);
        send(mk(0, 0, 2'b00, 2'b11, 1, 6'h3F));
        check("wd error bit", rd[14], 1'b1);
        tick(2000);
        check("wd stays off", fault_n, 1'b1);
        $display("test watchdog done");

        send(mk(0, 0, 2'b00, 2'b11, 0, 6'h3F));
        check("sleep with wake", reg_en, 1'b1);
        wake <= 1'b0;
        tick(10);
        send(mk(0, 0, 2'b00, 2'b11, 0, 6'h3F));
        check("sleep", reg_en, 1'b0);
        $display("test sleep done");
        complete_run();
    end
endmodule // ssw_top_tb_top

`default_nettype wire
